// ==== core/pmx_map.svh ====
// Purpose: register offsets, field positions and reset values of the management bank
// Assumes: register numbers are word indices; byte address is four times the index
// Notes: definitions only
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH

// register indices
`define PMX_IDX_EXPANSION 5'h06
`define PMX_IDX_RSVD_LO 5'h08
`define PMX_IDX_RSVD_HI 5'h0F
`define PMX_IDX_STATUS_CTRL 5'h10
`define PMX_IDX_SPECIAL 5'h11
`define PMX_IDX_ADDRESS 5'h12
`define PMX_IDX_FALSE_CARRIER 5'h13
`define PMX_IDX_DISCONNECT 5'h14

// expansion fields
`define PMX_EXP_PD_FAULT 4
`define PMX_EXP_LP_NP_ABLE 3
`define PMX_EXP_NP_ABLE 2
`define PMX_EXP_PAGE_RX 1
`define PMX_EXP_LP_AN_ABLE 0

// status and control fields
`define PMX_SC_DISC_EN 13
`define PMX_SC_TX_FC_EN 12
`define PMX_SC_DESER_SYNC 11
`define PMX_SC_PD_100 10
`define PMX_SC_PD_10 9
`define PMX_SC_POLARITY 8
`define PMX_SC_SPEED 1
`define PMX_SC_DUPLEX 0

// special control writable bits (bit 10 reserved)
`define PMX_SPC_WMASK 16'hFBFF
`define PMX_SPC_RESET 16'h0000
`define PMX_SC_RESET 2'h0

// fixed address field
`define PMX_PHY_ADDR 16'h0001

// bus answers
`define PMX_RESP_OKAY 2'h0
`define PMX_RESP_SLVERR 2'h2

`endif

// ==== core/pmx_pkg.sv ====
// Purpose: types of the management register bank
// Assumes: constants live in pmx_map.svh
// Notes: none
package pmx_pkg;

	// write path state
	typedef enum logic [1:0] {
		PMX_W_IDLE = 2'b00,
		PMX_W_RESP = 2'b01
	} pmx_wstate_e;

	// read path state
	typedef enum logic [1:0] {
		PMX_R_IDLE = 2'b00,
		PMX_R_RESP = 2'b01
	} pmx_rstate_e;

	// control outputs toward the phy datapath
	typedef struct packed {
		logic scrambler_bypass;
		logic enc_4b5b_bypass;
		logic force_h_pattern;
		logic force_34_pattern;
		logic force_link_good;
		logic tx_crs_disable;
		logic dyn_pd_disable;
		logic an_loopback;
		logic tx_tristate;
		logic rx_filter_bypass;
		logic auto_pol_disable;
		logic squelch_test_disable;
		logic ext_squelch_en;
		logic link_integrity_disable;
		logic jabber_disable;
		logic disconnect_en;
		logic tx_flow_ctrl_en;
	} pmx_ctrl_s;

	// status inputs from the phy datapath
	typedef struct packed {
		logic pd_fault_evt;
		logic page_rx_evt;
		logic lp_np_able;
		logic lp_an_able;
		logic local_np_able;
		logic deser_sync;
		logic pd_100;
		logic pd_10;
		logic pol_reversed;
		logic speed_100;
		logic full_duplex;
		logic false_carrier_evt;
		logic disconnect_evt;
	} pmx_stat_s;

endpackage

// ==== core/pmx_regs.sv ====
// Purpose: phy management extension registers behind an axi4-lite slave
// Assumes: inputs synchronous to sys_clk; events are one-cycle pulses
// Notes: read side effects happen when the read address is taken;
//   an event in the same cycle as its read clear wins;
//   both event counters freeze at all ones until read;
//   byte address is four times the register number;
//   unmapped or misaligned addresses answer slverr and change nothing;
//   reserved numbers 8 to 15 answer okay and read zero;
//   each answer comes one cycle after its request is taken;
//   status levels are shown live, so their defaults come from the datapath
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pmx_map.svh"

module pmx_regs (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// phy datapath side
	input wire pmx_pkg::pmx_stat_s phy_stat,
	output pmx_pkg::pmx_ctrl_s phy_ctrl
);

	// register map, byte address is four times the number:
	//   0x18 expansion, latched events and partner abilities
	//   0x20 to 0x3C reserved, read zero, answer okay
	//   0x40 status and control, 0x44 special control
	//   0x48 fixed address, 0x4C false carrier, 0x50 disconnect

	// next value of a saturating event counter with read clear; the event wins
	function automatic logic [15:0] pmx_count_next(input logic [15:0] cnt, input logic evt,
		input logic clr);
		if (clr) begin
			pmx_count_next = evt ? 16'h0001 : 16'h0000;
		end else if (evt && (cnt != 16'hFFFF)) begin
			pmx_count_next = cnt + 16'h0001;
		end else begin
			pmx_count_next = cnt;
		end
	endfunction

	// mapped index check, shared by both paths
	function automatic logic pmx_mapped(input logic [7:0] addr);
		logic [5:0] idx;
		idx = addr[7:2];
		pmx_mapped = (addr[1:0] == 2'h0) && (idx[5] == 1'b0) && (
			(idx[4:0] == `PMX_IDX_EXPANSION) ||
			((idx[4:0] >= `PMX_IDX_RSVD_LO) && (idx[4:0] <= `PMX_IDX_RSVD_HI)) ||
			((idx[4:0] >= `PMX_IDX_STATUS_CTRL) && (idx[4:0] <= `PMX_IDX_DISCONNECT)));
	endfunction

	// index from a byte address
	function automatic logic [4:0] pmx_index(input logic [7:0] addr);
		pmx_index = addr[6:2];
	endfunction

	// bus state
	pmx_pkg::pmx_wstate_e wstate_q;
	pmx_pkg::pmx_rstate_e rstate_q;

	// held write beat, address and data arrive in either order
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] awaddr_q;
	logic [15:0] wdata_q;
	logic [1:0] wstrb_q;

	// registered answers
	logic [1:0] bresp_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// register storage
	logic [1:0] sc_ctrl_q;
	logic [15:0] spc_q;
	logic pd_fault_q;
	logic page_rx_q;
	logic [15:0] false_cnt_q;
	logic [15:0] disc_cnt_q;

	// handshakes and decode
	logic [15:0] spc_wr;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic wr_fire;
	logic [15:0] rd_word;
	logic [4:0] rd_idx;
	logic [4:0] wr_idx;
	logic rd_exp;
	logic rd_false;
	logic rd_disc;
	logic wr_ok;

	// write channel handshakes; address and data taken in either order
	assign s_axi_awready = (wstate_q == pmx_pkg::PMX_W_IDLE) && !aw_held_q;
	assign s_axi_wready = (wstate_q == pmx_pkg::PMX_W_IDLE) && !w_held_q;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign wr_fire = (wstate_q == pmx_pkg::PMX_W_IDLE) &&
		(aw_held_q || aw_take) && (w_held_q || w_take);
	assign s_axi_bvalid = (wstate_q == pmx_pkg::PMX_W_RESP);
	assign s_axi_bresp = bresp_q;

	// read channel handshakes
	assign s_axi_arready = (rstate_q == pmx_pkg::PMX_R_IDLE);
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign s_axi_rvalid = (rstate_q == pmx_pkg::PMX_R_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// hold a write address taken before its data
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			aw_held_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end else if (aw_take) begin
			aw_held_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end
	end

	// hold write data taken before its address
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			w_held_q <= 1'b0;
			wdata_q <= 16'h0000;
			wstrb_q <= 2'h0;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end else if (w_take) begin
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata[15:0];
			wstrb_q <= s_axi_wstrb[1:0];
		end
	end

	// effective write beat, from holding registers or the bus directly
	logic [7:0] wr_addr;
	logic [15:0] wr_data;
	logic [1:0] wr_strb;
	assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
	assign wr_data = w_held_q ? wdata_q : s_axi_wdata[15:0];
	assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb[1:0];
	assign wr_idx = pmx_index(wr_addr);
	assign wr_ok = wr_fire && pmx_mapped(wr_addr);

	// special control word with the reserved bit forced low
	assign spc_wr = wr_data & `PMX_SPC_WMASK;

	// write response state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wstate_q <= pmx_pkg::PMX_W_IDLE;
		end else begin
			case (wstate_q)
				pmx_pkg::PMX_W_IDLE: begin
					if (wr_fire) begin
						wstate_q <= pmx_pkg::PMX_W_RESP;
					end
				end
				pmx_pkg::PMX_W_RESP: begin
					if (s_axi_bready) begin
						wstate_q <= pmx_pkg::PMX_W_IDLE;
					end
				end
				default: wstate_q <= pmx_pkg::PMX_W_IDLE;
			endcase
		end
	end

	// write answer code, fixed when the write is performed
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bresp_q <= `PMX_RESP_OKAY;
		end else if (wr_fire) begin
			bresp_q <= wr_ok ? `PMX_RESP_OKAY : `PMX_RESP_SLVERR;
		end
	end

	// status and control writable bits 13:12, reserved bits dropped
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sc_ctrl_q <= `PMX_SC_RESET;
		end else if (wr_ok && (wr_idx == `PMX_IDX_STATUS_CTRL) && wr_strb[1]) begin
			sc_ctrl_q <= wr_data[`PMX_SC_DISC_EN:`PMX_SC_TX_FC_EN];
		end
	end

	// special control register, per byte lane, bit 10 kept zero
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			spc_q <= `PMX_SPC_RESET;
		end else if (wr_ok && (wr_idx == `PMX_IDX_SPECIAL)) begin
			if (wr_strb[0]) begin
				spc_q[7:0] <= spc_wr[7:0];
			end
			if (wr_strb[1]) begin
				spc_q[15:8] <= spc_wr[15:8];
			end
		end
	end

	// read side effects decoded on the accepted read address
	assign rd_idx = pmx_index(s_axi_araddr);
	assign rd_exp = ar_take && pmx_mapped(s_axi_araddr) && (rd_idx == `PMX_IDX_EXPANSION);
	assign rd_false = ar_take && pmx_mapped(s_axi_araddr) &&
		(rd_idx == `PMX_IDX_FALSE_CARRIER);
	assign rd_disc = ar_take && pmx_mapped(s_axi_araddr) && (rd_idx == `PMX_IDX_DISCONNECT);

	// parallel detection fault latch; a new event wins over the read clear
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pd_fault_q <= 1'b0;
		end else begin
			pd_fault_q <= phy_stat.pd_fault_evt | (pd_fault_q & ~rd_exp);
		end
	end

	// page received latch; a new page wins over the read clear
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			page_rx_q <= 1'b0;
		end else begin
			page_rx_q <= phy_stat.page_rx_evt | (page_rx_q & ~rd_exp);
		end
	end

	// false carrier counter, freezes when full
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			false_cnt_q <= 16'h0000;
		end else begin
			false_cnt_q <= pmx_count_next(false_cnt_q, phy_stat.false_carrier_evt,
				rd_false);
		end
	end

	// disconnect counter, saturating
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			disc_cnt_q <= 16'h0000;
		end else begin
			disc_cnt_q <= pmx_count_next(disc_cnt_q, phy_stat.disconnect_evt,
				rd_disc);
		end
	end

	// read multiplexer
	always_comb begin
		rd_word = 16'h0000;
		case (rd_idx)
			`PMX_IDX_EXPANSION: begin
				rd_word[`PMX_EXP_PD_FAULT] = pd_fault_q;
				rd_word[`PMX_EXP_LP_NP_ABLE] = phy_stat.lp_np_able;
				rd_word[`PMX_EXP_NP_ABLE] = phy_stat.local_np_able;
				rd_word[`PMX_EXP_PAGE_RX] = page_rx_q;
				rd_word[`PMX_EXP_LP_AN_ABLE] = phy_stat.lp_an_able;
			end
			`PMX_IDX_STATUS_CTRL: begin
				rd_word[`PMX_SC_DISC_EN:`PMX_SC_TX_FC_EN] = sc_ctrl_q;
				rd_word[`PMX_SC_DESER_SYNC] = phy_stat.deser_sync;
				rd_word[`PMX_SC_PD_100] = phy_stat.pd_100;
				rd_word[`PMX_SC_PD_10] = phy_stat.pd_10;
				rd_word[`PMX_SC_POLARITY] = phy_stat.pol_reversed;
				rd_word[`PMX_SC_SPEED] = phy_stat.speed_100;
				rd_word[`PMX_SC_DUPLEX] = phy_stat.full_duplex;
			end
			`PMX_IDX_SPECIAL: rd_word = spc_q;
			`PMX_IDX_ADDRESS: rd_word = `PMX_PHY_ADDR;
			`PMX_IDX_FALSE_CARRIER: rd_word = false_cnt_q;
			`PMX_IDX_DISCONNECT: rd_word = disc_cnt_q;
			default: rd_word = 16'h0000;
		endcase
	end

	// read data and answer code, caught as the read address is taken
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdata_q <= 32'h00000000;
			rresp_q <= `PMX_RESP_OKAY;
		end else if (ar_take && pmx_mapped(s_axi_araddr)) begin
			rdata_q <= {16'h0000, rd_word};
			rresp_q <= `PMX_RESP_OKAY;
		end else if (ar_take) begin
			rdata_q <= 32'h00000000;
			rresp_q <= `PMX_RESP_SLVERR;
		end
	end

	// read response state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rstate_q <= pmx_pkg::PMX_R_IDLE;
		end else begin
			case (rstate_q)
				pmx_pkg::PMX_R_IDLE: begin
					if (ar_take) begin
						rstate_q <= pmx_pkg::PMX_R_RESP;
					end
				end
				pmx_pkg::PMX_R_RESP: begin
					if (s_axi_rready) begin
						rstate_q <= pmx_pkg::PMX_R_IDLE;
					end
				end
				default: rstate_q <= pmx_pkg::PMX_R_IDLE;
			endcase
		end
	end

	// control outputs straight from the registers
	always_comb begin
		phy_ctrl.disconnect_en = sc_ctrl_q[1];
		phy_ctrl.tx_flow_ctrl_en = sc_ctrl_q[0];
		phy_ctrl.scrambler_bypass = spc_q[15];
		phy_ctrl.enc_4b5b_bypass = spc_q[14];
		phy_ctrl.force_h_pattern = spc_q[13];
		phy_ctrl.force_34_pattern = spc_q[12];
		phy_ctrl.force_link_good = spc_q[11];
		phy_ctrl.tx_crs_disable = spc_q[9];
		phy_ctrl.dyn_pd_disable = spc_q[8];
		phy_ctrl.an_loopback = spc_q[7];
		phy_ctrl.tx_tristate = spc_q[6];
		phy_ctrl.rx_filter_bypass = spc_q[5];
		phy_ctrl.auto_pol_disable = spc_q[4];
		phy_ctrl.squelch_test_disable = spc_q[3];
		phy_ctrl.ext_squelch_en = spc_q[2];
		phy_ctrl.link_integrity_disable = spc_q[1];
		phy_ctrl.jabber_disable = spc_q[0];
	end

endmodule

// ==== test/pmx_mgmt_master.sv ====
// Purpose: station controller model issuing axi4-lite cycles
// Assumes: one write or one read at a time
// Notes: readies are looked at on the falling edge, where settled
`timescale 1ns/1ps
module pmx_mgmt_master (
	// clock
	input wire logic sys_clk,
	// write channels
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// read channels
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// set when an answer never came
	logic hang = 1'b0;
	// idle bus at time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// one write; payload inverted once released
	task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic aw, w, b, ta, tw, tk;
		{aw, w, b} = 3'h7;
		r = 2'h3;
		@(posedge sys_clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (int i = 0; i < 40 && (aw || w || b); i++) begin
			@(negedge sys_clk);
			ta = aw && s_axi_awready;
			tw = w && s_axi_wready;
			tk = b && s_axi_bvalid;
			if (tk) r = s_axi_bresp;
			@(posedge sys_clk);
			if (ta) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			if (tw) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
			if (tk) s_axi_bready <= 1'b0;
			{aw, w, b} = {aw && !ta, w && !tw, b && !tk};
		end
		hang = hang || aw || w || b;
	endtask
	// one read
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, b, ta, tk;
		{ar, b} = 2'h3;
		{d, r} = '1;
		@(posedge sys_clk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		for (int i = 0; i < 40 && (ar || b); i++) begin
			@(negedge sys_clk);
			ta = ar && s_axi_arready;
			tk = b && s_axi_rvalid;
			if (tk) {d, r} = {s_axi_rdata, s_axi_rresp};
			@(posedge sys_clk);
			if (ta) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
			if (tk) s_axi_rready <= 1'b0;
			{ar, b} = {ar && !ta, b && !tk};
		end
		hang = hang || ar || b;
	endtask
endmodule

// ==== test/pmx_regs_assertions.sv ====
// Purpose: port checks of the management register bank
// Assumes: read data lands one cycle after the read address is taken
// Notes: bound to pmx_regs from the bench top file
`timescale 1ns/1ps
`include "pmx_map.svh"
module pmx_regs_assertions (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// read channels and write answer
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	// datapath side
	input wire pmx_pkg::pmx_stat_s phy_stat,
	input wire pmx_pkg::pmx_ctrl_s phy_ctrl
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// read address taken at this edge, by target
	logic ar_go, rsvd;
	assign ar_go = s_axi_arvalid && s_axi_arready;
	assign rsvd = ar_go && s_axi_araddr inside {[8'h20:8'h3C]} && s_axi_araddr[1:0] == 2'h0;
	a_ctrl_reset: assert property (disable iff (1'b0) reset |=> phy_ctrl == 17'h0)
		else $error("control outputs not cleared by reset");
	a_ctrl_by_write: assert property (!$stable(phy_ctrl) |-> $rose(s_axi_bvalid))
		else $error("control outputs moved without a write");
	a_exp_fields: assert property (ar_go && s_axi_araddr == 8'h18 |=> s_axi_rdata[15:5] == 11'h0
		&& s_axi_rdata[3] == $past(phy_stat.lp_np_able) && s_axi_rdata[2] == $past(phy_stat.local_np_able)
		&& s_axi_rdata[0] == $past(phy_stat.lp_an_able)) else $error("expansion fields wrong");
	a_status_live: assert property (ar_go && s_axi_araddr == 8'h40 |=> s_axi_rdata[15:14] == 2'h0
		&& s_axi_rdata[11:8] == $past(phy_stat[7:4]) && s_axi_rdata[7:2] == 6'h0
		&& s_axi_rdata[1:0] == $past(phy_stat[3:2])) else $error("status fields wrong");
	a_addr_fixed: assert property (ar_go && s_axi_araddr == 8'h48 |=> s_axi_rdata == 32'h1)
		else $error("fixed address wrong");
	a_rsvd_zero: assert property (rsvd |=> s_axi_rdata == 32'h0)
		else $error("reserved register not zero");
	a_rsvd_okay: assert property (rsvd |=> s_axi_rvalid && s_axi_rresp == `PMX_RESP_OKAY)
		else $error("reserved register answer wrong");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("upper read half not zero");
endmodule

// ==== test/pmx_regs_tb.sv ====
// Purpose: self-checking bench of the management register bank
// Assumes: datapath levels held steady around each read
// Notes: a model of the bank predicts every read and control output
`timescale 1ns/1ps
`include "pmx_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module pmx_regs_tb;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	pmx_pkg::pmx_stat_s phy_stat;
	pmx_pkg::pmx_ctrl_s phy_ctrl;
	// counters and model state
	int err_count = 0;
	int checked = 0;
	int fc = 0;
	int dc = 0;
	logic [15:0] spc = 16'h0;
	logic [1:0] sc = 2'h0;
	logic pf = 1'b0;
	logic pr = 1'b0;
	logic [15:0] seed = 16'hDFE9;
	logic [7:0] amap[$] = '{8'h18, 8'h1C, 8'h20, 8'h3C, 8'h40, 8'h41, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54};
	always #12.5 sys_clk = ~sys_clk;
	pmx_regs pmx_regs_inst (.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .phy_stat, .phy_ctrl);
	pmx_mgmt_master mst (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	// lfsr source
	function automatic logic [15:0] rnd();
		seed = seed[0] ? (seed >> 1) ^ 16'hB400 : seed >> 1;
		return seed;
	endfunction
	// expected answer code
	function automatic logic [1:0] resp(input logic [7:0] a);
		if (a[1:0] == 2'h0 && (a == 8'h18 || a inside {[8'h20:8'h50]})) return `PMX_RESP_OKAY;
		return `PMX_RESP_SLVERR;
	endfunction
	// expected read data, applying clear on read
	function automatic logic [31:0] expv(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			8'h18: v = {pf, phy_stat.lp_np_able, phy_stat.local_np_able, pr, phy_stat.lp_an_able};
			8'h40: v = {sc, phy_stat[7:4], 6'h0, phy_stat[3:2]};
			8'h44: v = spc;
			8'h48: v = 32'h1;
			8'h4C: v = fc;
			8'h50: v = dc;
		endcase
		if (a == 8'h18) {pf, pr} = 2'h0;
		if (a == 8'h4C) fc = 0;
		if (a == 8'h50) dc = 0;
		return v;
	endfunction
	// model of a write, byte lanes honoured
	function automatic void wm(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [15:0] m;
		m = {{8{s[1]}}, {8{s[0]}}} & (a == 8'h44 ? `PMX_SPC_WMASK : 16'h3000);
		if (a == 8'h44) spc = (spc & ~m) | (d[15:0] & m);
		if (a == 8'h40) sc = (sc & ~m[13:12]) | (d[13:12] & m[13:12]);
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] r;
		mst.write(a, d, s, r);
		if (mst.hang) summarize();
		wm(a, d, s);
		`CHK(r, resp(a))
	endtask
	task automatic rd(input logic [7:0] a);
		logic [31:0] d, e;
		logic [1:0] r;
		mst.read(a, d, r);
		if (mst.hang) summarize();
		e = expv(a);
		`CHK(d, e)
		`CHK(r, resp(a))
	endtask
	// event pulse of n cycles: 0 fault, 1 page, 2 false carrier, 3 disconnect
	task automatic ev(input int k, input int n);
		int b;
		b = k < 2 ? 12 - k : 3 - k;
		@(posedge sys_clk);
		phy_stat[b] <= 1'b1;
		repeat (n) @(posedge sys_clk);
		phy_stat[b] <= 1'b0;
		case (k)
			0: pf = 1'b1;
			1: pr = 1'b1;
			2: fc = fc + n > 65535 ? 65535 : fc + n;
			default: dc = dc + n > 65535 ? 65535 : dc + n;
		endcase
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic summarize();
		err_count += mst.hang;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// main sequence
	initial begin
		logic [15:0] t;
		phy_stat = 13'h0;
		phy_stat.pd_100 = 1'b1;
		phy_stat.pd_10 = 1'b1;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		foreach (amap[i]) rd(amap[i]);
		`CHK(phy_ctrl, 17'h0)
		done("reset values");
		for (int i = 0; i < 6; i++) begin
			wr(8'h44, {rnd(), rnd()}, i == 5 ? 4'h1 : 4'hF);
			wr(8'h40, {rnd(), rnd()}, 4'hF);
			rd(8'h44);
			`CHK(phy_ctrl, {spc[15:11], spc[9:0], sc})
		end
		done("control words");
		for (int i = 0; i < 6; i++) begin
			t = rnd();
			@(posedge sys_clk);
			phy_stat[10:2] <= t[8:0];
			rd(8'h40);
			rd(8'h18);
		end
		done("live status");
		ev(0, 1);
		ev(1, 3);
		rd(8'h18);
		rd(8'h18);
		ev(2, 5);
		ev(3, 7);
		repeat (2) begin
			rd(8'h4C);
			rd(8'h50);
		end
		ev(3, 65540);
		rd(8'h50);
		done("events and counters");
		foreach (amap[i]) if (!(amap[i] inside {8'h40, 8'h44})) wr(amap[i], '1, 4'hF);
		foreach (amap[i]) rd(amap[i]);
		`CHK(phy_ctrl, {spc[15:11], spc[9:0], sc})
		done("reserved places");
		wr(8'h44, 32'h0000A5A5, 4'hF);
		ev(2, 3);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		spc = 16'h0000;
		sc = 2'h0;
		fc = 0;
		`CHK(phy_ctrl, 17'h0)
		rd(8'h4C);
		rd(8'h44);
		done("mid-run reset");
		summarize();
	end
endmodule
bind pmx_regs pmx_regs_assertions pmx_regs_assertions_inst (.sys_clk, .reset, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid,
	.phy_stat, .phy_ctrl);
